// >>> common/host_port_pkg.sv
// Purpose: constants for the host port pin configuration block
// Assumes: AHB-Lite register access, 16 multi-function port pins
// Notes:   offsets are byte addresses, one aligned word per register
//
// Functional notes
// (RULE1) strobe polarity bit picks active level
// (RULE2) single request: push-pull or open drain
// (RULE3) double request: both requests push-pull or open-drain
// (RULE4) software writes reserved bit 7 as zero
// (RULE5) interface off makes every pin gpio
// (RULE6) single mode, both enables: ack input
// (RULE7) single mode, either enable clear: ack gpio
// (RULE8) request enable, single mode: request output
// (RULE9) request enable, double: transmit and receive requests
// (RULE10) request enable clear: both pins gpio
// (RULE11) select enable: chip select or address 10
// (RULE12) select enable clear: select pin gpio
// (RULE13) muxed mode: address 9 enable picks role
// (RULE14) address 9 enable ignored outside muxed mode
// (RULE15) muxed mode: address 8 enable picks role
// (RULE16) address 8 enable ignored outside muxed mode
// (RULE17) gpio port off disconnects gpio pins
// (RULE18) gpio port enable leaves host pins alone
// (RULE19) single strobe: direction from read/write line
// (RULE20) dual strobe: direction from active strobe
// (RULE21) muxed mode latches low address from bus
// (RULE22) dual strobe select picks strobe mode
// (RULE23) pin roles follow control bits combinationally
`default_nettype none
package host_port_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  OFS_PIN_CTRL = 8'h00;
  localparam logic [7:0]  OFS_IF_CTRL  = 8'h04;
  localparam logic [7:0]  OFS_DIR      = 8'h08;
  localparam logic [7:0]  OFS_DATA     = 8'h0C;
  localparam logic [7:0]  OFS_STATUS   = 8'h10;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

  // ==========================================================
  // reset values
  localparam logic [15:0] PIN_CTRL_RST = 16'h0000;
  localparam logic [15:0] DIR_RST      = 16'h0000;
  localparam logic [15:0] DATA_RST     = 16'h0000;
  localparam logic [0:0]  IF_CTRL_RST  = 1'h0;

  // ==========================================================
  // port_pin_control_reg fields
  localparam int B_GPIO_ON  = 0;
  localparam int B_A8_EN    = 1;
  localparam int B_A9_EN    = 2;
  localparam int B_SEL_EN   = 3;
  localparam int B_REQ_EN   = 4;
  localparam int B_ACK_EN   = 5;
  localparam int B_IF_ON    = 6;
  localparam int B_RSVD     = 7;
  localparam int B_REQ_OD   = 8;
  localparam int B_STB_POL  = 9;
  localparam int B_AS_POL   = 10;
  localparam int B_MUX      = 11;
  localparam int B_DUAL     = 12;
  localparam int B_SEL_POL  = 13;
  localparam int B_REQ_POL  = 14;
  localparam int B_ACK_POL  = 15;

  // interface_control_reg field
  localparam int B_DBL_REQ  = 0;

  // status fields
  localparam int S_ADDR     = 0;
  localparam int S_STROBE   = 4;
  localparam int S_LAST_WR  = 5;
  localparam int S_ACK      = 6;

  // ==========================================================
  // pin positions
  localparam int NPIN       = 16;
  localparam int P_AD       = 0;
  localparam int P_A0_AS    = 8;
  localparam int P_A1_A8    = 9;
  localparam int P_A2_A9    = 10;
  localparam int P_SEL_A10  = 11;
  localparam int P_STB0     = 12;
  localparam int P_STB1     = 13;
  localparam int P_REQ      = 14;
  localparam int P_ACK      = 15;

endpackage : host_port_pkg
`default_nettype wire

// >>> hw/gpio_pin_mux.sv
// Purpose: per-pin choice between host function and gpio
// Assumes: host_role bit high means the pin serves the host port
// Notes:   no high-impedance value here, only output enables
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_mux
  import host_port_pkg::*;
(
  input  wire logic [NPIN-1:0] host_role,
  input  wire logic [NPIN-1:0] host_out,
  input  wire logic [NPIN-1:0] host_oe,
  input  wire logic            port_on,
  input  wire logic [NPIN-1:0] dir,
  input  wire logic [NPIN-1:0] data,
  input  wire logic [NPIN-1:0] pin_in,
  output logic      [NPIN-1:0] pin_out,
  output logic      [NPIN-1:0] pin_oe,
  output logic      [NPIN-1:0] gpio_in
);

  // ==========================================================
  // selection
  wire [NPIN-1:0] gpio_live = ~host_role & {NPIN{port_on}}; // [RULE17]

  // host pins ignore port_on entirely
  assign pin_oe  = (host_role & host_oe) | (gpio_live & dir); // [RULE18]
  assign pin_out = (host_role & host_out) | (~host_role & data);
  // disconnected inputs read as zero, not as floating pins
  assign gpio_in = pin_in & gpio_live; // [RULE17]

endmodule : gpio_pin_mux
`default_nettype wire

// >>> hw/host_port_pin_config.sv
// Purpose: pin role selection and access qualification of host port
// Assumes: pins synchronous to sys_clk, single AHB-Lite slave
// Notes:   zero wait state slave, response always OKAY
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_config
  import host_port_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic      [31:0]     hrdata,
  input  wire logic [NPIN-1:0] pin_in,
  output logic      [NPIN-1:0] pin_out,
  output logic      [NPIN-1:0] pin_oe,
  input  wire logic            tx_req,
  input  wire logic            rx_req,
  input  wire logic [7:0]      host_rdata,
  output logic                 host_ack,
  output logic                 host_rd_pulse,
  output logic                 host_wr_pulse,
  output logic      [2:0]      host_addr,
  output logic      [2:0]      host_hi_addr,
  output logic      [7:0]      host_wdata
);

  // ==========================================================
  // helpers
  function automatic logic act_level(input logic lvl, input logic pol);
    act_level = pol ? lvl : ~lvl;
  endfunction : act_level

  // returns {oe, out}; open drain only ever pulls low
  function automatic logic [1:0] drive_req(input logic src,
                                           input logic pol,
                                           input logic od);
    logic lvl;
    lvl = act_level(src, pol);
    drive_req = od ? {~lvl, 1'b0} : {1'b1, lvl};
  endfunction : drive_req

  // ==========================================================
  // reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ==========================================================
  // AHB-Lite slave
  logic        wen_q;
  logic [7:0]  aoff_q;
  logic [15:0] ctrl_q;
  logic [0:0]  ifc_q;
  logic [15:0] dir_q;
  logic [15:0] data_q;

  wire addr_ph = hsel & htrans[1] & hready;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wen_q  <= 1'b0;
      aoff_q <= 8'h00;
    end else if (hready) begin
      wen_q  <= addr_ph & hwrite;
      aoff_q <= haddr[7:0];
    end
  end

  wire wr_ctrl = wen_q & (aoff_q == OFS_PIN_CTRL);
  wire wr_ifc  = wen_q & (aoff_q == OFS_IF_CTRL);
  wire wr_dir  = wen_q & (aoff_q == OFS_DIR);
  wire wr_data = wen_q & (aoff_q == OFS_DATA);

  // reserved bit stored as written; software keeps it zero [RULE4]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= PIN_CTRL_RST;
      ifc_q  <= IF_CTRL_RST;
      dir_q  <= DIR_RST;
      data_q <= DATA_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata[15:0];
      if (wr_ifc)  ifc_q  <= hwdata[B_DBL_REQ];
      if (wr_dir)  dir_q  <= hwdata[15:0];
      if (wr_data) data_q <= hwdata[15:0];
    end
  end

  // ==========================================================
  // control fields
  wire if_on   = ctrl_q[B_IF_ON];
  wire port_on = ctrl_q[B_GPIO_ON];
  wire req_en  = ctrl_q[B_REQ_EN];
  wire ack_en  = ctrl_q[B_ACK_EN];
  wire sel_en  = ctrl_q[B_SEL_EN];
  wire a9_en   = ctrl_q[B_A9_EN];
  wire a8_en   = ctrl_q[B_A8_EN];
  wire req_od  = ctrl_q[B_REQ_OD];
  wire stb_pol = ctrl_q[B_STB_POL];
  wire mux     = ctrl_q[B_MUX];
  wire dual    = ctrl_q[B_DUAL];
  wire dbl     = ifc_q[B_DBL_REQ];

  // ==========================================================
  // pin roles, straight from the register bits [RULE23]
  wire role_req = if_on & req_en; // [RULE8] [RULE9] [RULE10]
  // double mode ignores the ack enable [RULE6] [RULE7]
  wire role_ack = if_on & req_en & (dbl | ack_en);
  wire role_sel = if_on & sel_en; // [RULE11] [RULE12]
  // address enables only count in muxed mode [RULE14] [RULE16]
  wire role_a9  = if_on & (~mux | a9_en); // [RULE13]
  wire role_a8  = if_on & (~mux | a8_en); // [RULE15]

  // interface off leaves nothing to the host [RULE5]
  wire [NPIN-1:0] host_role = {role_ack, role_req, if_on, if_on,
                               role_sel, role_a9, role_a8, if_on,
                               {8{if_on}}};

  // ==========================================================
  // access qualification
  wire as_act = mux & act_level(pin_in[P_A0_AS], ctrl_q[B_AS_POL]);
  wire cs_act = act_level(pin_in[P_SEL_A10], ctrl_q[B_SEL_POL]);
  // muxed bus carries no chip select; the pin is address 10 there
  wire sel    = ~role_sel | mux | cs_act; // [RULE11]
  wire stb0   = act_level(pin_in[P_STB0], stb_pol); // [RULE1]
  wire stb1   = act_level(pin_in[P_STB1], stb_pol); // [RULE1]
  wire rw_hi  = pin_in[P_STB1];

  // single: one strobe plus read/write line [RULE19] [RULE22]
  // dual: the active strobe is the direction [RULE20] [RULE22]
  wire rd_act = if_on & sel & (dual ? stb0 : stb0 & rw_hi);
  wire wr_act = if_on & sel & (dual ? stb1 : stb0 & ~rw_hi);

  // ==========================================================
  // access state
  logic       rd_q;
  logic       wr_q;
  logic       last_wr_q;
  logic [2:0] lat_q;
  logic [7:0] rdata_q;
  logic       ack_q;
  logic       rdp_q;
  logic       wrp_q;
  logic [2:0] addr_q;
  logic [2:0] hi_q;
  logic [7:0] wdata_q;

  wire [2:0] addr_d = mux ? lat_q : pin_in[P_A2_A9:P_A0_AS]; // [RULE21]
  wire [2:0] hi_d   = {pin_in[P_SEL_A10] & role_sel & mux,
                       pin_in[P_A2_A9] & role_a9 & mux,
                       pin_in[P_A1_A8] & role_a8 & mux};
  wire ack_d = role_ack & ~dbl
             & act_level(pin_in[P_ACK], ctrl_q[B_ACK_POL]); // [RULE6]

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q      <= 1'b0;
      wr_q      <= 1'b0;
      last_wr_q <= 1'b0;
      lat_q     <= 3'h0;
      rdata_q   <= 8'h00;
      ack_q     <= 1'b0;
      rdp_q     <= 1'b0;
      wrp_q     <= 1'b0;
      addr_q    <= 3'h0;
      hi_q      <= 3'h0;
      wdata_q   <= 8'h00;
    end else begin
      rd_q    <= rd_act;
      wr_q    <= wr_act;
      rdp_q   <= rd_act & ~rd_q;
      // write pulse follows the trailing edge of the strobe; write data is sampled while the strobe is active
      wrp_q   <= wr_q & ~wr_act;
      ack_q   <= ack_d;
      addr_q  <= addr_d;
      hi_q    <= hi_d;
      rdata_q <= host_rdata;
      if (as_act) lat_q <= pin_in[2:0]; // [RULE21]
      if (wr_act) wdata_q <= pin_in[P_AD+7:P_AD];
      if (rd_act | wr_act) last_wr_q <= wr_act;
    end
  end

  assign host_ack      = ack_q;
  assign host_rd_pulse = rdp_q;
  assign host_wr_pulse = wrp_q;
  assign host_addr     = addr_q;
  assign host_hi_addr  = hi_q;
  assign host_wdata    = wdata_q;

  // ==========================================================
  // host-driven pins
  wire       req_src = dbl ? tx_req : (tx_req | rx_req);
  wire [1:0] req_drv = drive_req(req_src, ctrl_q[B_REQ_POL],
                                 req_od); // [RULE2] [RULE3]
  wire [1:0] rrq_drv = drive_req(rx_req, ctrl_q[B_REQ_POL],
                                 req_od); // [RULE3]
  // ack pin drives only as receive request in double mode [RULE9]
  wire       ack_oe  = dbl & rrq_drv[1];

  wire [NPIN-1:0] host_oe  = {ack_oe, req_drv[1], 6'h00,
                              {8{rd_q}}};
  wire [NPIN-1:0] host_out = {rrq_drv[0], req_drv[0], 6'h00,
                              rdata_q};

  logic [NPIN-1:0] gpio_in;

  gpio_pin_mux u_pin_mux (
    .host_role (host_role),
    .host_out  (host_out),
    .host_oe   (host_oe),
    .port_on   (port_on),
    .dir       (dir_q),
    .data      (data_q),
    .pin_in    (pin_in),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .gpio_in   (gpio_in)
  );

  // ==========================================================
  // read data
  wire [15:0] data_rd = (gpio_in & ~dir_q) | (data_q & dir_q);
  wire [15:0] stat_rd = {9'h000, ack_q, last_wr_q, rd_q | wr_q,
                         1'b0, lat_q};

  assign hrdata = (aoff_q == OFS_PIN_CTRL) ? {16'h0000, ctrl_q} :
                  (aoff_q == OFS_IF_CTRL)  ? {31'h00000000, ifc_q} :
                  (aoff_q == OFS_DIR)      ? {16'h0000, dir_q} :
                  (aoff_q == OFS_DATA)     ? {16'h0000, data_rd} :
                  (aoff_q == OFS_STATUS)   ? {16'h0000, stat_rd} :
                  32'h00000000;

  // ==========================================================
  // checks
  property p_req_push;
    @(posedge sys_clk) disable iff (!rst_n)
      (if_on && req_en && !req_od) |-> pin_oe[P_REQ];
  endproperty
  a_req_push: assert property (p_req_push) // [RULE2]
    else $error("request pin not driven in push-pull");

  property p_req_od;
    @(posedge sys_clk) disable iff (!rst_n)
      (if_on && req_en && req_od)
        |-> !(pin_oe[P_REQ] && pin_out[P_REQ]);
  endproperty
  a_req_od: assert property (p_req_od) // [RULE2]
    else $error("open-drain request drove high");

  property p_dbl_rrq;
    @(posedge sys_clk) disable iff (!rst_n)
      (if_on && req_en && dbl && !req_od)
        |-> (pin_oe[P_ACK] && pin_out[P_ACK] ==
             act_level(rx_req, ctrl_q[B_REQ_POL]));
  endproperty
  a_dbl_rrq: assert property (p_dbl_rrq) // [RULE3]
    else $error("receive request output wrong");

  property p_ack_in;
    @(posedge sys_clk) disable iff (!rst_n)
      (if_on && req_en && !dbl && ack_en &&
       pin_in[P_ACK] == ctrl_q[B_ACK_POL])
        |=> (host_ack && !pin_oe[P_ACK]);
  endproperty
  a_ack_in: assert property (p_ack_in) // [RULE6]
    else $error("acknowledge input not seen");

  property p_if_off;
    @(posedge sys_clk) disable iff (!rst_n)
      !if_on |-> (host_role == 16'h0000 && !host_rd_pulse ##1
                  !host_wr_pulse || if_on);
  endproperty
  a_if_off: assert property (p_if_off) // [RULE5]
    else $error("host function active with interface off");

  property p_a9_nomux;
    @(posedge sys_clk) disable iff (!rst_n)
      (if_on && !mux) |-> (host_role[P_A2_A9] && host_role[P_A1_A8]);
  endproperty
  a_a9_nomux: assert property (p_a9_nomux) // [RULE14]
    else $error("address enable honoured outside muxed mode");

  property p_gpio_off;
    @(posedge sys_clk) disable iff (!rst_n)
      !port_on |-> ((pin_oe & ~host_role) == 16'h0000);
  endproperty
  a_gpio_off: assert property (p_gpio_off) // [RULE17]
    else $error("disconnected gpio pin driven");

  property p_wr_end;
    @(posedge sys_clk) disable iff (!rst_n)
      (if_on && dual && sel && stb1) ##1 !wr_act |=> host_wr_pulse;
  endproperty
  a_wr_end: assert property (p_wr_end) // [RULE20]
    else $error("dual strobe write not reported");

  property p_mux_latch;
    @(posedge sys_clk) disable iff (!rst_n)
      as_act |=> ##1 (!mux || host_addr == $past(pin_in[2:0], 2)
                      || $past(as_act));
  endproperty
  a_mux_latch: assert property (p_mux_latch) // [RULE21]
    else $error("muxed address not latched");

  property p_ctrl_apply;
    @(posedge sys_clk) disable iff (!rst_n)
      (addr_ph && hwrite && haddr[7:0] == OFS_PIN_CTRL)
        ##1 !hwdata[B_IF_ON] |=> (host_role == 16'h0000);
  endproperty
  a_ctrl_apply: assert property (p_ctrl_apply) // [RULE23]
    else $error("control write did not change pin roles");

endmodule : host_port_pin_config
`default_nettype wire

// >>> sim/host_bus_model.sv
// Purpose: host processor side of the parallel host bus
// Assumes: select, address strobe and strobes stay driven when idle
// Notes:   released lines toggle every cycle, never keep old value
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic        sys_clk,
  output logic      [15:0] drv,
  output logic      [15:0] en
);
  logic [15:0] hv;
  logic [15:0] flt;

  // =====
  // idle: deselected, strobes high
  initial begin
    hv  = 16'h3900;
    en  = 16'h3900;
    flt = 16'h0000;
  end
  always @(posedge sys_clk) flt <= ~flt;
  assign drv = (hv & en) | (flt & ~en);

  task automatic put(input logic [15:0] m, input logic [15:0] v);
    en <= en | m;
    hv <= (hv & ~m) | (v & m);
  endtask : put

  // =====
  // byte access: select, strobe, two idle cycles after
  task automatic access(input logic dual, input logic pol, input logic rd,
                        input logic cs, input logic [2:0] a,
                        input logic [7:0] d);
    logic [1:0] idle;
    idle = dual ? {~pol, ~pol} : {rd, ~pol};
    put(rd ? 16'h3F00 : 16'h3FFF, {2'h0, idle, ~cs, a, d});
    @(posedge sys_clk);
    if (dual) begin
      hv[rd ? 12 : 13] <= pol;
    end else begin
      hv[12] <= pol;   // direction on pin 13
    end
    repeat (3) @(posedge sys_clk);
    hv[13:12] <= idle;
    repeat (2) @(posedge sys_clk);
    hv[11] <= 1'b1;
    en[7:0] <= 8'h00;
    // one edge apart, so a following access never reassigns hv or en
    @(posedge sys_clk);
  endtask : access

  // address phase on shared bus, strobe active low
  task automatic latch(input logic [7:0] a);
    put(16'h01FF, {8'h00, a});
    @(posedge sys_clk);
    hv[8] <= 1'b1;
    @(posedge sys_clk);
    en[7:0] <= 8'h00;
  endtask : latch
endmodule : host_bus_model
`default_nettype wire

// >>> sim/host_port_pin_config_tb.sv
// Purpose: self-checking bench for host port pin configuration
// Assumes: zero wait AHB slave, host model on the pins
// Notes:   expectations queued by driver, popped by monitor
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_config_tb;
  import host_port_pkg::*;
  typedef struct packed {
    logic [2:0]  k;
    logic [31:0] m;
    logic [31:0] v;
  } note_t;
  typedef struct packed {
    logic [15:0] c;
    logic        i;
    logic        t;
    logic [15:0] m;
    logic [15:0] oe;
    logic [15:0] om;
    logic [15:0] ov;
  } row_t;
  logic        sys_clk, arst_n, hsel, hwrite, tx_req, rx_req, hresp;
  logic        hreadyout, host_ack, host_rd_pulse, host_wr_pulse;
  logic        rd_dp, pol, dual;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, host_addr, host_hi_addr, a;
  logic [7:0]  host_rdata, host_wdata, rd_cnt, wr_cnt, erd, ewr;
  logic [7:0]  pseq, pseen, rdat, wdat;
  logic [15:0] pin_out, pin_oe, m_drv, m_en;
  wire  [15:0] pin_in = (pin_oe & pin_out) | (~pin_oe & m_drv);
  wire         hready = hreadyout;
  note_t       q [$];
  int          err_total, checks, cyc;
  integer      seed;
  string       nm [5] = '{"pin_oe", "pin_out", "host_side", "pulses",
                          "hrdata"};
  row_t rows [10] = '{
    '{16'h0001, 1'b0, 1'b1, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hA55A},
    '{16'h0000, 1'b0, 1'b1, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000},
    '{16'h0078, 1'b0, 1'b1, 16'hFFFF, 16'h4000, 16'h4000, 16'h0000},
    '{16'h0178, 1'b0, 1'b0, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000},
    '{16'h0059, 1'b0, 1'b1, 16'hC000, 16'hC000, 16'h8000, 16'h8000},
    '{16'h0048, 1'b0, 1'b1, 16'hC000, 16'h0000, 16'h0000, 16'h0000},
    '{16'h0058, 1'b1, 1'b1, 16'hC000, 16'hC000, 16'hC000, 16'h8000},
    '{16'h0158, 1'b1, 1'b1, 16'hC000, 16'h4000, 16'h4000, 16'h0000},
    '{16'h0041, 1'b0, 1'b1, 16'h0E00, 16'h0800, 16'h0000, 16'h0000},
    '{16'h0841, 1'b0, 1'b1, 16'h0600, 16'h0600, 16'h0000, 16'h0000}
  };

  host_port_pin_config host_port_pin_config_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .tx_req(tx_req), .rx_req(rx_req),
    .host_rdata(host_rdata), .host_ack(host_ack),
    .host_rd_pulse(host_rd_pulse), .host_wr_pulse(host_wr_pulse),
    .host_addr(host_addr), .host_hi_addr(host_hi_addr),
    .host_wdata(host_wdata));
  host_bus_model host_bus_model_inst (
    .sys_clk(sys_clk), .drv(m_drv), .en(m_en));

  // =====
  // monitor
  function automatic logic [31:0] obs(input logic [2:0] k);
    case (k)
      3'd0: obs = {16'h0, pin_oe};
      3'd1: obs = {16'h0, pin_out};
      3'd2: obs = {16'h0, hresp, host_wdata, host_addr, host_hi_addr,
                   host_ack};
      default: obs = {16'h0, rd_cnt, wr_cnt};
    endcase
  endfunction : obs
  task automatic take(input logic [31:0] seen);
    note_t n;
    n = (q.size() == 0) ? note_t'{3'd4, 32'h0, 32'h1} : q.pop_front();
    checks++;
    if ((seen & n.m) !== n.v) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm[n.k], n.v, seen & n.m);
    end
  endtask : take
  always @(posedge sys_clk) begin
    if (rd_dp) take(hrdata);
    rd_dp <= hsel & htrans[1] & ~hwrite & hready;
    rd_cnt <= rd_cnt + {7'h0, host_rd_pulse};
    wr_cnt <= wr_cnt + {7'h0, host_wr_pulse};
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  always @(negedge sys_clk) begin
    if (pseq != pseen) begin
      pseen = pseq;
      take(obs(q.size() == 0 ? 3'd0 : q[0].k));
    end
  end

  // =====
  // drivers
  task automatic probe(input logic [2:0] k, input logic [31:0] m, v);
    q.push_back('{k, m, v});
    pseq <= pseq + 8'h1;
    @(posedge sys_clk);
  endtask : probe
  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    if (!w) q.push_back('{3'd4, 32'hFFFFFFFF, d});
    hsel <= 1'b1;
    htrans <= HTRANS_NSEQ;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge sys_clk); while (hready !== 1'b1);
  endtask : ahb
  task automatic conclude();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    {arst_n, hsel, hwrite, tx_req, rx_req, rd_dp} = 6'h0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    {host_rdata, rd_cnt, wr_cnt, erd, ewr, pseq, pseen} = 56'h0;
    {err_total, checks, cyc, seed} = {96'h0, 32'd59};
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int o = 0; o < 6; o++) begin
      ahb(1'b0, 8'(o * 4), 32'h0);   // all registers reset to zero
    end
    probe(3'd0, 32'hFFFF, 32'h0);
    ahb(1'b1, 8'h14, 32'hFFFFFFFF);   // unmapped: write dropped
    ahb(1'b0, 8'h14, 32'h0);
    ahb(1'b1, OFS_DATA, 32'h0000A55A);
    ahb(1'b0, OFS_DATA, 32'h0);
    ahb(1'b1, OFS_DIR, 32'h0000FFFF);
    ahb(1'b0, OFS_DATA, 32'h0000A55A);
    foreach (rows[i]) begin
      tx_req <= rows[i].t;
      ahb(1'b1, OFS_IF_CTRL, {31'h0, rows[i].i});
      ahb(1'b1, OFS_PIN_CTRL, {16'h0, rows[i].c});   // bit 7 zero
      probe(3'd0, {16'h0, rows[i].m}, {16'h0, rows[i].oe});
      probe(3'd1, {16'h0, rows[i].om}, {16'h0, rows[i].ov});
      ahb(1'b0, OFS_PIN_CTRL, {16'h0, rows[i].c});
    end
    ahb(1'b1, OFS_IF_CTRL, 32'h0);
    ahb(1'b1, OFS_PIN_CTRL, 32'h00000078);
    host_bus_model_inst.put(16'h8000, 16'h0000);
    repeat (2) @(posedge sys_clk);
    probe(3'd2, 32'h8001, 32'h1);
    ahb(1'b1, OFS_PIN_CTRL, 32'h00000840);
    a = 3'($random(seed));
    host_bus_model_inst.latch({5'h0, a});
    probe(3'd2, 32'h807F, {25'h0, a, 4'h0});
    ahb(1'b0, OFS_STATUS, {29'h0, a});
    ahb(1'b1, OFS_DIR, 32'h0);
    for (int s = 0; s < 4; s++) begin
      pol = s[1];
      dual = s[0];
      ahb(1'b1, OFS_PIN_CTRL, {19'h0, dual, 2'h0, pol, 9'h048});
      a = 3'($random(seed));
      rdat = 8'($random(seed));
      wdat = 8'($random(seed));
      host_rdata <= rdat;
      fork
        host_bus_model_inst.access(dual, pol, 1'b1, 1'b1, a, 8'h00);
        begin
          repeat (3) @(posedge sys_clk);
          probe(3'd0, 32'hFF, 32'hFF);
          probe(3'd1, 32'hFF, {24'h0, rdat});
        end
      join
      erd++;
      host_bus_model_inst.access(dual, pol, 1'b0, 1'b1, a, wdat);
      ewr++;
      repeat (2) @(posedge sys_clk);
      probe(3'd3, 32'hFFFF, {16'h0, erd, ewr});
      probe(3'd2, 32'hFFFF, {17'h0, wdat, a, 4'h0});
    end
    host_bus_model_inst.access(dual, pol, 1'b1, 1'b0, a, 8'h00);
    repeat (2) @(posedge sys_clk);
    probe(3'd3, 32'hFFFF, {16'h0, erd, ewr});
    conclude();
  end
endmodule : host_port_pin_config_tb
`default_nettype wire
